// [inc/scaler_pkg.sv]
package scaler_pkg;

    // ----------------
    // Coefficient storage shape
    // ----------------
    localparam int NUM_BANKS       = 2;
    localparam int NUM_PHASES      = 17;
    localparam int NUM_TAPS        = 7;
    localparam int NUM_WORDS       = 60;
    localparam int COEF_W          = 16;
    localparam logic [5:0] LAST_WORD      = 6'h3b;
    localparam logic [2:0] CENTRE_TAP     = 3'h3;
    localparam int SLOT2_LSB       = 16;

    // ----------------
    // Register select codes
    // ----------------
    typedef enum logic [3:0] {
        sel_power_gating      = 4'b0000,
        sel_control           = 4'b0001,
        sel_vertical_phase    = 4'b0010,
        sel_horizontal_phase  = 4'b0011,
        sel_adaptive_control  = 4'b0100,
        sel_window_position   = 4'b0101,
        sel_window_size       = 4'b0110,
        sel_bank0_index       = 4'b0111,
        sel_bank1_index       = 4'b1000,
        sel_bank0_data        = 4'b1001,
        sel_bank1_data        = 4'b1010,
        sel_seam_excess       = 4'b1011
    } reg_sel_e;

    // ----------------
    // Field positions
    // ----------------
    localparam int CTRL_ENABLE_BIT      = 31;
    localparam int CTRL_LUMA_H_BANK     = 0;
    localparam int CTRL_LUMA_V_BANK     = 1;
    localparam int CTRL_CHROMA_H_BANK   = 2;
    localparam int CTRL_CHROMA_V_BANK   = 3;
    localparam int CTRL_ALLOW_BIT       = 4;
    localparam int WINSZ_WIDTH_LSB      = 16;

    // ----------------
    // Values after reset
    // ----------------
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [15:0] EXCESS_RESET = 16'h0000;

    // ----------------
    // Carriers
    // ----------------
    typedef logic [NUM_WORDS-1:0][31:0] coef_bank_t;

    typedef struct packed {
        logic [31:0] scaler_power_gating;
        logic [31:0] scaler_control;
    } control_group_s;

    typedef struct packed {
        logic [31:0] scaler_vertical_initial_phase;
        logic [31:0] scaler_horizontal_initial_phase;
        logic [31:0] scaler_adaptive_control;
        logic [31:0] scaler_window_position;
        logic [31:0] scaler_window_size;
    } window_group_s;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } pixel_s;

endpackage

// [hw/pipe_scaler.sv]
// Overview of operation
// R1: Two coefficient banks; horizontal and vertical filters each pick a bank.
// R2: Luma and chroma scalers each pick their own bank independently.
// R3: Each bank holds 17 phases by 7 taps in 60 words.
// R4: Two coefficients per word, low slot first; slot 2 of word 3Bh reserved.
// R5: Coefficients reached through per-bank index and data registers.
// R6: Software loads centre tap 1, others 0, for nearest-neighbour scaling.
// R7: Pipe off: a control or size write updates its own group at once.
// R8: Older generations: armed control group updates at vertical blank rise.
// R9: Older generations: armed window-size group updates after frame start.
// R10: Generation eleven: armed update at vertical blank rise only when allowed.
// R11: Pipe on: any window-size write arms double buffering.
// R12: Older generations: arm cleared at next window-size trigger.
// R13: Generation eleven: arm cleared at next allowed vertical blank rise.
// R14: Gating, control and coefficients: control group; the rest: size group.
// R15: Software programs coefficients, gating, control, phases, position, then size.
// R16: Enabling a disabled scaler starts powering its subsystem arrays.
// R17: With scaler and pipe on, coefficients apply through arming alone.
// R18: Older generations: software writes window size outside vertical blank.
// R19: After any change with pipe on, software rewrites window size.
// R20: Overlap pixels after scaling are dropped before leaving the pipe.
// R21: Software adds excesses to source size, window size and seam register.
// R22: Software sets transcoder active width to panel width without overlap.

// ----------------
// Pixel FIFO
// ----------------
module pixel_fifo #(
    parameter int W     = 33,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,        // Core clock
    input  wire logic         reset,      // Async reset, high
    input  wire logic         ce,         // Clock enable
    input  wire logic         in_valid,   // Write request
    output logic              in_ready,   // Room for a word
    input  wire logic [W-1:0] in_data,    // Word written
    output logic              out_valid,  // Word available
    input  wire logic         out_ready,  // Word taken
    output logic [W-1:0]      out_data    // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             count;
    } fifo_state_s;

    fifo_state_s st;
    fifo_state_s next_st;
    logic        push;
    logic        pop;

    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rptr];

    always_comb begin
        next_st = st;
        push    = in_valid & in_ready;
        pop     = out_valid & out_ready;
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = (st.wptr == AW'(DEPTH-1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH-1)) ? '0 : st.rptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

// ----------------
// Scaler registers, double buffering, seam trimming
// ----------------
module pipe_scaler #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                 clk, // 10 MHz core clock
    input  wire logic                 reset, // Async reset, high
    input  wire logic                 ce, // Clock enable
    input  wire logic                 display_generation_eleven, // Newer trigger scheme
    input  wire logic                 pipe_enable, // Pipe running
    input  wire logic                 vertical_blank, // Vertical blank level
    input  wire logic                 frame_start, // Frame start pulse
    input  wire logic                 wr_en, // Register write strobe
    input  wire scaler_pkg::reg_sel_e wr_sel, // Register written
    input  wire logic [31:0]          wr_data, // Write data
    input  wire logic                 coef_rd_en, // Coefficient data read
    input  wire logic                 coef_rd_bank, // Bank read
    output logic [31:0]               coef_rd_data, // Coefficient pair read
    output logic                      coef_rd_valid, // Read data valid pulse
    output scaler_pkg::control_group_s active_control, // Live control group
    output scaler_pkg::window_group_s  active_window, // Live window-size group
    output logic                      armed, // Double buffering armed
    output logic                      luma_h_bank, // Luma horizontal bank
    output logic                      luma_v_bank, // Luma vertical bank
    output logic                      chroma_h_bank, // Chroma horizontal bank
    output logic                      chroma_v_bank, // Chroma vertical bank
    input  wire logic                 filter_bank, // Filter lookup bank
    input  wire logic [4:0]           filter_phase, // Filter lookup phase
    input  wire logic [2:0]           filter_tap, // Filter lookup tap
    output logic [scaler_pkg::COEF_W-1:0] filter_coef, // Looked-up coefficient
    output logic                      array_powerup, // Subsystem power-up pulse
    input  wire logic                 pix_in_valid, // Scaled pixel in
    output logic                      pix_in_ready, // Pixel accepted
    input  wire scaler_pkg::pixel_s   pix_in, // Pixel and end of line
    input  wire logic                 seam_on_left, // Overlap at line start
    output logic                      pix_out_valid, // Pixel to port
    input  wire logic                 pix_out_ready, // Port takes pixel
    output scaler_pkg::pixel_s        pix_out // Pixel to port
);
    typedef struct packed {
        scaler_pkg::control_group_s   pend_ctrl;
        scaler_pkg::control_group_s   act_ctrl;
        scaler_pkg::window_group_s    pend_win;
        scaler_pkg::window_group_s    act_win;
        logic [1:0][scaler_pkg::NUM_WORDS-1:0][31:0] pend_coef;
        logic [1:0][scaler_pkg::NUM_WORDS-1:0][31:0] act_coef;
        logic [1:0][5:0]              coef_index;
        logic [15:0]                  seam_excess;
        logic                         armed;
        logic                         vblank_q;
        logic                         frame_start_q;
        logic [31:0]                  coef_rd_data;
        logic                         coef_rd_valid;
        logic [scaler_pkg::COEF_W-1:0] filter_coef;
        logic                         powerup;
        logic [15:0]                  column;
        logic                         out_valid;
        scaler_pkg::pixel_s           out_pix;
    } scaler_state_s;

    scaler_state_s      st;
    scaler_state_s      next_st;
    logic               fifo_valid;
    logic               fifo_pop;
    scaler_pkg::pixel_s fifo_pix;
    logic               vb_rise;
    logic               ctrl_trig;
    logic               win_trig;
    logic               arm_set;
    logic               disarm;
    logic               drop;
    logic [15:0]        keep_width;
    logic               wr_bank;
    logic [5:0]         wr_index;

    // Returns one coefficient of a bank; the reserved slot reads zero
    function automatic logic [scaler_pkg::COEF_W-1:0] coef_at(
        input logic [scaler_pkg::NUM_WORDS-1:0][31:0] bank,
        input logic [6:0]                             loc
    );
        logic [5:0]  word;
        logic [31:0] pair;
        word = loc[6:1];
        pair = (word > scaler_pkg::LAST_WORD) ? 32'h0000_0000 : bank[word];
        if (loc[0]) begin
            coef_at = pair[scaler_pkg::SLOT2_LSB +: scaler_pkg::COEF_W]; // R4
        end else begin
            coef_at = pair[scaler_pkg::COEF_W-1:0];
        end
    endfunction

    // Seam overlap sits after the scaler, so the FIFO decouples the scaler
    // burst rate from the port while dropped pixels drain without stalling
    pixel_fifo #(
        .W     ($bits(scaler_pkg::pixel_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (pix_in_valid),
        .in_ready  (pix_in_ready),
        .in_data   (pix_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_pix)
    );

    assign active_control = st.act_ctrl;
    assign active_window  = st.act_win;
    assign armed          = st.armed;
    assign coef_rd_data   = st.coef_rd_data;
    assign coef_rd_valid  = st.coef_rd_valid;
    assign filter_coef    = st.filter_coef;
    assign array_powerup  = st.powerup;
    assign pix_out_valid  = st.out_valid;
    assign pix_out        = st.out_pix;
    assign luma_h_bank    = st.act_ctrl.scaler_control[scaler_pkg::CTRL_LUMA_H_BANK];   // R1
    assign luma_v_bank    = st.act_ctrl.scaler_control[scaler_pkg::CTRL_LUMA_V_BANK];   // R1
    assign chroma_h_bank  = st.act_ctrl.scaler_control[scaler_pkg::CTRL_CHROMA_H_BANK]; // R2
    assign chroma_v_bank  = st.act_ctrl.scaler_control[scaler_pkg::CTRL_CHROMA_V_BANK]; // R2

    assign keep_width = st.act_win.scaler_window_size[scaler_pkg::WINSZ_WIDTH_LSB +: 16]
                        - st.seam_excess;
    assign drop       = seam_on_left ? (st.column < st.seam_excess)
                                     : (st.column >= keep_width);
    assign fifo_pop   = fifo_valid & (drop | ~st.out_valid | pix_out_ready);
    assign wr_bank    = (wr_sel == scaler_pkg::sel_bank1_data);
    assign wr_index   = st.coef_index[wr_bank];

    always_comb begin
        next_st               = st;
        next_st.coef_rd_valid = 1'b0;
        next_st.powerup       = 1'b0;
        next_st.vblank_q      = vertical_blank;
        next_st.frame_start_q = frame_start;
        vb_rise   = vertical_blank & ~st.vblank_q;
        ctrl_trig = 1'b0;
        win_trig  = 1'b0;
        arm_set   = 1'b0;
        disarm    = 1'b0;

        // ----------------
        // Group and coefficient writes land in the pending copies; seam excess is written live
        // ----------------
        if (wr_en) begin
            case (wr_sel)
                scaler_pkg::sel_power_gating: begin
                    next_st.pend_ctrl.scaler_power_gating = wr_data;
                end
                scaler_pkg::sel_control: begin
                    next_st.pend_ctrl.scaler_control = wr_data;
                    ctrl_trig = ~pipe_enable; // R7
                end
                scaler_pkg::sel_vertical_phase: begin
                    next_st.pend_win.scaler_vertical_initial_phase = wr_data;
                end
                scaler_pkg::sel_horizontal_phase: begin
                    next_st.pend_win.scaler_horizontal_initial_phase = wr_data;
                end
                scaler_pkg::sel_adaptive_control: begin
                    next_st.pend_win.scaler_adaptive_control = wr_data;
                end
                scaler_pkg::sel_window_position: begin
                    next_st.pend_win.scaler_window_position = wr_data;
                end
                scaler_pkg::sel_window_size: begin
                    next_st.pend_win.scaler_window_size = wr_data;
                    win_trig = ~pipe_enable; // R7
                    arm_set  = pipe_enable;  // R11
                end
                scaler_pkg::sel_bank0_index: begin
                    next_st.coef_index[0] = wr_data[5:0]; // R5
                end
                scaler_pkg::sel_bank1_index: begin
                    next_st.coef_index[1] = wr_data[5:0]; // R5
                end
                scaler_pkg::sel_bank0_data,
                scaler_pkg::sel_bank1_data: begin
                    // Out-of-range index is ignored; reserved slot stays zero
                    if (wr_index <= scaler_pkg::LAST_WORD) begin // R3
                        next_st.pend_coef[wr_bank][wr_index] =
                            (wr_index == scaler_pkg::LAST_WORD)
                            ? {16'h0000, wr_data[15:0]} : wr_data; // R4 R5
                    end
                end
                scaler_pkg::sel_seam_excess: begin
                    next_st.seam_excess = wr_data[15:0];
                end
                default: begin
                end
            endcase
        end

        if (coef_rd_en) begin
            next_st.coef_rd_data  = (st.coef_index[coef_rd_bank] <= scaler_pkg::LAST_WORD)
                                    ? st.pend_coef[coef_rd_bank][st.coef_index[coef_rd_bank]]
                                    : 32'h0000_0000; // R5
            next_st.coef_rd_valid = 1'b1;
        end

        // ----------------
        // Double-buffer triggers
        // ----------------
        if (pipe_enable && st.armed) begin
            if (display_generation_eleven) begin
                if (vb_rise && st.pend_ctrl.scaler_control[scaler_pkg::CTRL_ALLOW_BIT]) begin
                    ctrl_trig = 1'b1; // R10
                    win_trig  = 1'b1; // R10
                    disarm    = 1'b1; // R13
                end
            end else begin
                if (vb_rise) begin
                    ctrl_trig = 1'b1; // R8
                end
                // Taken one cycle after the frame start pulse
                if (st.frame_start_q) begin
                    win_trig = 1'b1; // R9
                    disarm   = 1'b1; // R12
                end
            end
        end

        // A new arm in the disarm cycle survives it
        if (disarm) begin
            next_st.armed = 1'b0;
        end
        if (arm_set) begin
            next_st.armed = 1'b1; // R11
        end

        if (ctrl_trig) begin
            // Coefficients ride with the control group, no control rewrite needed with the pipe on
            next_st.act_ctrl = next_st.pend_ctrl;  // R14
            next_st.act_coef = next_st.pend_coef;  // R14 R17
            if (next_st.pend_ctrl.scaler_control[scaler_pkg::CTRL_ENABLE_BIT]
                    && !st.act_ctrl.scaler_control[scaler_pkg::CTRL_ENABLE_BIT]) begin
                next_st.powerup = 1'b1; // R16
            end
        end
        if (win_trig) begin
            next_st.act_win = next_st.pend_win; // R14
        end

        // Location is formed at 7 bits so phase 16 does not wrap
        next_st.filter_coef = coef_at(st.act_coef[filter_bank],
                                      7'(filter_phase) * 7'(scaler_pkg::NUM_TAPS)
                                      + 7'(filter_tap)); // R3

        // ----------------
        // Seam trimming at the pipe output
        // ----------------
        if (st.out_valid && pix_out_ready) begin
            next_st.out_valid = 1'b0;
        end
        if (fifo_pop) begin
            next_st.column = fifo_pix.last ? 16'h0000 : st.column + 16'h0001;
            if (!drop) begin
                next_st.out_valid = 1'b1;
                next_st.out_pix   = fifo_pix;
            end else if (fifo_pix.last && st.out_valid) begin
                // Line end dropped: mark the held pixel as the line's last
                next_st.out_pix.last = 1'b1; // R20
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st             <= '0;
            st.seam_excess <= scaler_pkg::EXCESS_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

// [test/scaler_props.sv]
// ----------------
// Port-level checks for the scaler
// ----------------
module scaler_props #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic                      clk, // Clock
    input wire logic                      reset, // Reset
    input wire logic                      ce, // Run
    input wire logic                      display_generation_eleven, // Scheme
    input wire logic                      pipe_enable, // Pipe on
    input wire logic                      vertical_blank, // Blank
    input wire logic                      frame_start, // Frame start
    input wire logic                      wr_en, // Write
    input wire scaler_pkg::reg_sel_e      wr_sel, // Select
    input wire logic [31:0]               wr_data, // Data
    input wire logic                      coef_rd_en, // Read
    input wire logic                      coef_rd_valid, // Read valid
    input wire scaler_pkg::control_group_s active_control, // Live control
    input wire logic                      armed, // Armed
    input wire logic                      luma_h_bank, // Bank pick
    input wire logic                      array_powerup, // Power-up
    input wire logic                      pix_out_valid, // Out valid
    input wire logic                      pix_out_ready, // Out ready
    input wire scaler_pkg::pixel_s        pix_out // Out pixel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_rd; ce && coef_rd_en |=> coef_rd_valid; endproperty
    property p_arm;
        ce && pipe_enable && wr_en && wr_sel == scaler_pkg::sel_window_size |=> armed;
    endproperty
    property p_ctrl_now;
        ce && !pipe_enable && wr_en && wr_sel == scaler_pkg::sel_control
            |=> active_control.scaler_control == $past(wr_data);
    endproperty
    // Old scheme may take the window trigger one or two cycles after the pulse
    property p_old_disarm;
        !display_generation_eleven && $fell(armed)
            |-> $past(frame_start, 2) || $past(frame_start, 3);
    endproperty
    property p_new_disarm;
        display_generation_eleven && $fell(armed) |-> $past(vertical_blank);
    endproperty
    property p_powerup;
        array_powerup |-> active_control.scaler_control[31] &&
            !$past(active_control.scaler_control[31]);
    endproperty
    property p_bank;
        ce && !pipe_enable && wr_en && wr_sel == scaler_pkg::sel_control
            |=> luma_h_bank == $past(wr_data[0]);
    endproperty
    property p_hold;
        pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out);
    endproperty

    a_rd: assert property (p_rd) else $error("read valid missing");
    a_arm: assert property (p_arm) else $error("size write did not arm");
    a_ctrl_now: assert property (p_ctrl_now) else $error("control not immediate");
    a_old_disarm: assert property (p_old_disarm) else $error("early disarm");
    a_new_disarm: assert property (p_new_disarm) else $error("disarm off blank");
    a_powerup: assert property (p_powerup) else $error("stray power-up");
    a_bank: assert property (p_bank) else $error("bank pick wrong");
    a_hold: assert property (p_hold) else $error("output not held");
    c_arm: cover property (ce && pipe_enable && wr_en && wr_sel == scaler_pkg::sel_window_size);
    c_disarm: cover property ($fell(armed));
    c_stall: cover property (pix_out_valid && !pix_out_ready);
endmodule

bind pipe_scaler scaler_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk, .reset, .ce,
    .display_generation_eleven, .pipe_enable, .vertical_blank, .frame_start, .wr_en,
    .wr_sel, .wr_data, .coef_rd_en, .coef_rd_valid, .active_control, .armed, .luma_h_bank,
    .array_powerup, .pix_out_valid, .pix_out_ready, .pix_out);

// [test/pipe_scaler_coef_double_buffer_bench.sv]
module pipe_scaler_coef_double_buffer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, reset = 1'h1, ce = 1'h1, display_generation_eleven = 1'h1;
    logic pipe_enable = 1'h0, vertical_blank = 1'h0, frame_start = 1'h0, wr_en = 1'h0;
    logic coef_rd_en = 1'h0, coef_rd_bank = 1'h0, filter_bank = 1'h0, seam_on_left = 1'h0;
    logic pix_in_valid = 1'h0, pix_out_ready = 1'h0;
    logic [4:0] filter_phase = 5'h00;
    logic [2:0] filter_tap = 3'h0;
    logic [31:0] wr_data = 32'h0000_0000;
    scaler_pkg::reg_sel_e wr_sel = scaler_pkg::sel_power_gating;
    scaler_pkg::pixel_s pix_in = '0;
    scaler_pkg::pixel_s pix_out;
    scaler_pkg::control_group_s active_control;
    scaler_pkg::window_group_s active_window;
    logic [31:0] coef_rd_data;
    logic [15:0] filter_coef;
    logic coef_rd_valid, armed, luma_h_bank, luma_v_bank, chroma_h_bank, chroma_v_bank;
    logic array_powerup, pix_in_ready, pix_out_valid;
    int err_count = 0, compares = 0, n;
    logic [31:0] got[$];

    pipe_scaler DUT (.clk, .reset, .ce, .display_generation_eleven, .pipe_enable,
        .vertical_blank, .frame_start, .wr_en, .wr_sel, .wr_data, .coef_rd_en, .coef_rd_bank,
        .coef_rd_data, .coef_rd_valid, .active_control, .active_window, .armed, .luma_h_bank,
        .luma_v_bank, .chroma_h_bank, .chroma_v_bank, .filter_bank, .filter_phase,
        .filter_tap, .filter_coef, .array_powerup, .pix_in_valid, .pix_in_ready, .pix_in,
        .seam_on_left, .pix_out_valid, .pix_out_ready, .pix_out);

    initial forever #50 clk = ~clk;
    initial begin
        #1_000_000;
        err_count++;
        conclude();
    end
    always @(posedge clk) if (pix_out_valid && pix_out_ready) got.push_back(pix_out.data);

    // ----------------
    // Access tasks
    // ----------------
    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(scaler_pkg::reg_sel_e s, logic [31:0] d);
        @(negedge clk);
        wr_en = 1'h1;
        wr_sel = s;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'h0;
    endtask
    task automatic rd(logic b, logic [31:0] e);
        @(negedge clk);
        coef_rd_en = 1'h1;
        coef_rd_bank = b;
        @(negedge clk);
        coef_rd_en = 1'h0;
        chk({31'h0, coef_rd_valid}, 32'h0000_0001);
        chk(coef_rd_data, e);
    endtask
    // Blank held two cycles so the trigger lands whatever its pipeline depth
    task automatic blank();
        @(negedge clk);
        vertical_blank = 1'h1;
        repeat (2) @(negedge clk);
        vertical_blank = 1'h0;
    endtask
    task automatic frame();
        @(negedge clk);
        frame_start = 1'h1;
        @(negedge clk);
        frame_start = 1'h0;
        repeat (2) @(negedge clk);
    endtask
    function automatic logic [31:0] nn(int w);
        return {16'((2 * w + 1) % 7 == 3), 16'((2 * w) % 7 == 3)};
    endfunction
    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------
    // Test sequence
    // ----------------
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'h0;
        chk({31'h0, armed}, 32'h0000_0000);
        for (int w = 0; w < 60; w++) begin
            wr(scaler_pkg::sel_bank1_index, 32'(w));
            wr(scaler_pkg::sel_bank1_data, nn(w));
        end
        wr(scaler_pkg::sel_bank1_index, 32'h0000_0001);
        rd(1'h1, 32'h0001_0000);
        wr(scaler_pkg::sel_bank0_index, 32'h0000_003b);
        wr(scaler_pkg::sel_bank0_data, 32'hffff_ffff);
        rd(1'h0, 32'h0000_ffff);
        wr(scaler_pkg::sel_bank0_index, 32'h0000_003c);
        wr(scaler_pkg::sel_bank0_data, 32'hffff_ffff);
        rd(1'h0, 32'h0000_0000);
        wr(scaler_pkg::sel_power_gating, 32'h0000_0001);
        wr(scaler_pkg::sel_control, 32'h8000_0005);
        chk({31'h0, array_powerup}, 32'h0000_0001);
        chk(active_control.scaler_control, 32'h8000_0005);
        chk(active_control.scaler_power_gating, 32'h0000_0001);
        chk({28'h0, chroma_v_bank, chroma_h_bank, luma_v_bank, luma_h_bank}, 32'h0000_0005);
        filter_bank = 1'h1;
        for (int p = 0; p < 17; p++) begin
            for (int t = 0; t < 7; t++) begin
                filter_phase = 5'(p);
                filter_tap = 3'(t);
                @(negedge clk);
                chk({16'h0, filter_coef}, (t == 3) ? 32'h0000_0001 : 32'h0000_0000);
            end
        end
        pipe_enable = 1'h1;
        wr(scaler_pkg::sel_control, 32'h8000_001a);
        chk(active_control.scaler_control, 32'h8000_0005);
        wr(scaler_pkg::sel_window_size, 32'h0020_0008);
        chk({31'h0, armed}, 32'h0000_0001);
        blank();
        chk(active_control.scaler_control, 32'h8000_001a);
        chk(active_window.scaler_window_size, 32'h0020_0008);
        chk({31'h0, armed}, 32'h0000_0000);
        wr(scaler_pkg::sel_control, 32'h8000_0000);
        wr(scaler_pkg::sel_window_size, 32'h0020_0010);
        blank();
        chk({31'h0, armed}, 32'h0000_0001);
        chk(active_control.scaler_control, 32'h8000_001a);
        wr(scaler_pkg::sel_control, 32'h8000_0010);
        blank();
        chk(active_window.scaler_window_size, 32'h0020_0010);
        chk({31'h0, armed}, 32'h0000_0000);
        display_generation_eleven = 1'h0;
        wr(scaler_pkg::sel_control, 32'h8000_0013);
        wr(scaler_pkg::sel_window_size, 32'h0020_0004);
        blank();
        chk(active_control.scaler_control, 32'h8000_0013);
        chk(active_window.scaler_window_size, 32'h0020_0010);
        chk({31'h0, armed}, 32'h0000_0001);
        frame();
        chk(active_window.scaler_window_size, 32'h0020_0004);
        chk({31'h0, armed}, 32'h0000_0000);
        pipe_enable = 1'h0;
        wr(scaler_pkg::sel_window_size, 32'h0020_0000);
        wr(scaler_pkg::sel_seam_excess, 32'h0000_0004);
        // Far side stalls until the FIFO refuses, then drains
        for (n = 0; n < 32; n++) begin
            if (pix_in_ready !== 1'h1) begin
                chk(32'(n), 32'h0000_0011);
                pix_out_ready = 1'h1;
                @(negedge clk);
            end
            pix_in_valid = 1'h1;
            pix_in = {32'(n), n == 31};
            @(negedge clk);
        end
        pix_in_valid = 1'h0;
        repeat (40) @(negedge clk);
        chk(32'(got.size()), 32'h0000_001c);
        for (int i = 0; i < 28; i++) chk(got[i], 32'(i));
        conclude();
    end
endmodule
